//--- rss_pkg.sv
// Shared constants and types for the reset source sequencer.
package rss_pkg;

	// ============================================================
	// Fixed fetch addresses and mode value
	localparam logic [15:0] MODE_ADDR     = 16'hFFFD;
	localparam logic [15:0] VEC_HI_ADDR   = 16'hFFFE;
	localparam logic [15:0] VEC_LO_ADDR   = 16'hFFFF;
	localparam logic [7:0]  MODE_SINGLE   = 8'h00;

	// ============================================================
	// Timing
	localparam int          INSTR_CYC_CLKS = 4;
	localparam int          INT_RST_INSTR  = 4;
	localparam int          INT_RST_CLKS   = INSTR_CYC_CLKS * INT_RST_INSTR;
	localparam logic [7:0]  INT_RST_LEN    = 8'(INT_RST_CLKS);
	localparam int          TBT_DIV_BITS   = 18;

	// ============================================================
	// Register bus
	localparam logic [3:0]  CTRL_OFS      = 4'h0;
	localparam logic [3:0]  STAT_OFS      = 4'h1;
	localparam logic [3:0]  WDT_OFS       = 4'h2;
	localparam logic [3:0]  VEC_OFS       = 4'h3;
	localparam int          CTRL_SWRST_B  = 0;
	localparam int          CTRL_WDEN_B   = 1;
	localparam int          CTRL_SUBCLK_B = 2;
	localparam int          CTRL_STOP_B   = 3;
	localparam logic [7:0]  CTRL_RST_VAL  = 8'h01;

	// ============================================================
	// Reset sequencer states
	typedef enum logic [2:0] {
		RSS_POR,
		RSS_STAB,
		RSS_INTRST,
		RSS_EXTWAIT,
		RSS_FETCH_MODE,
		RSS_FETCH_HI,
		RSS_FETCH_LO,
		RSS_RUN
	} rss_state_t;

endpackage : rss_pkg

//--- rss_rom.sv
// Small ROM holding the mode byte and the reset vector, registered read.
`timescale 1ns/1ps
module rss_rom #(
	parameter logic [15:0] VECTOR = 16'h8000
) (
	input  wire logic        sys_clk,
	input  wire logic [15:0] addr,
	output logic      [7:0]  rdata
);
	logic [7:0] nxt_rdata;

	always_comb begin
		case (addr)
			rss_pkg::MODE_ADDR:   nxt_rdata = rss_pkg::MODE_SINGLE;
			rss_pkg::VEC_HI_ADDR: nxt_rdata = VECTOR[15:8];
			rss_pkg::VEC_LO_ADDR: nxt_rdata = VECTOR[7:0];
			default:              nxt_rdata = 8'hFF;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		rdata <= nxt_rdata;
	end
endmodule : rss_rom

//--- rss_seq.sv
// Reset source sequencer: combines reset causes, stabilisation wait and mode fetch.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rss_seq #(
	parameter bit          POR_OPT   = 1'b1,
	parameter bit          ROUT_OPT  = 1'b1,
	parameter int          STAB_BITS = 14,
	parameter int          WDT_BITS  = 16,
	parameter logic [15:0] VECTOR    = 16'h8000
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        ext_rst_pin_b_in,
	output logic             ext_rst_pin_out,
	output logic             ext_rst_pin_oe,
	input  wire logic        op_select_pin_hi,
	input  wire logic        op_select_pin_lo,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             cpu_rst_b,
	output logic             cpu_start,
	output logic      [15:0] cpu_start_pc,
	output logic             ram_clear,
	output logic             mode_err
);
	if (STAB_BITS < 2 || STAB_BITS > rss_pkg::TBT_DIV_BITS) begin : g_bad_stab
		$error("STAB_BITS out of range");
	end
	if (WDT_BITS < 4 || WDT_BITS > 24) begin : g_bad_wdt
		$error("WDT_BITS out of range");
	end

	// ============================================================
	// Pin synchroniser
	logic pin_s1_ff;
	logic pin_s2_ff;
	always_ff @(posedge sys_clk) begin
		pin_s1_ff <= ext_rst_pin_b_in;
		pin_s2_ff <= pin_s1_ff;
	end
	wire pin_low = !pin_s2_ff;

	// ============================================================
	// Registers
	rss_pkg::rss_state_t state_ff;
	rss_pkg::rss_state_t nxt_state;
	logic [7:0]          ctrl_ff;
	logic [WDT_BITS-1:0] wdt_ff;
	logic [rss_pkg::TBT_DIV_BITS-1:0] tbt_ff;
	logic [7:0]          irst_cnt_ff;
	logic [15:0]         vec_ff;
	logic [1:0]          cause_ff;
	logic                subclk_at_rst_ff;
	wire  [7:0]          rom_rdata;

	wire in_run     = (state_ff == rss_pkg::RSS_RUN);
	wire wr_ctrl    = reg_wr && reg_addr == rss_pkg::CTRL_OFS && in_run;
	wire wr_wdt     = reg_wr && reg_addr == rss_pkg::WDT_OFS && in_run;
	wire sw_rst     = wr_ctrl && !reg_wdata[rss_pkg::CTRL_SWRST_B];
	wire wd_en      = ctrl_ff[rss_pkg::CTRL_WDEN_B];
	wire wd_over    = in_run && wd_en && (&wdt_ff);
	wire subclk     = ctrl_ff[rss_pkg::CTRL_SUBCLK_B];
	wire stopped    = ctrl_ff[rss_pkg::CTRL_STOP_B];
	wire osc_off    = subclk || stopped;
	wire stab_done  = &tbt_ff[STAB_BITS-1:0];
	wire irst_done  = irst_cnt_ff == rss_pkg::INT_RST_LEN - 8'h01;
	wire int_cause  = sw_rst || wd_over;
	wire pin_in_run = in_run && pin_low;

	// ============================================================
	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			rss_pkg::RSS_POR:
				nxt_state = POR_OPT ? rss_pkg::RSS_STAB : rss_pkg::RSS_EXTWAIT;
			rss_pkg::RSS_STAB:
				if (stab_done)
					nxt_state = rss_pkg::RSS_EXTWAIT;
			rss_pkg::RSS_INTRST:
				if (irst_done)
					nxt_state = subclk_at_rst_ff ? rss_pkg::RSS_STAB
					                             : rss_pkg::RSS_EXTWAIT;
			rss_pkg::RSS_EXTWAIT:
				if (!pin_low)
					nxt_state = rss_pkg::RSS_FETCH_MODE;
			rss_pkg::RSS_FETCH_MODE:
				nxt_state = rss_pkg::RSS_FETCH_HI;
			rss_pkg::RSS_FETCH_HI:
				nxt_state = rss_pkg::RSS_FETCH_LO;
			rss_pkg::RSS_FETCH_LO:
				nxt_state = rss_pkg::RSS_RUN;
			rss_pkg::RSS_RUN:
				if (pin_in_run)
					nxt_state = (POR_OPT && osc_off) ? rss_pkg::RSS_STAB
					                                 : rss_pkg::RSS_EXTWAIT;
				else if (int_cause)
					nxt_state = rss_pkg::RSS_INTRST;
			default:
				nxt_state = rss_pkg::RSS_POR;
		endcase
	end

	// A pin reset during fetch restarts the fetch so a half-read vector is never used.
	wire fetch_st = state_ff == rss_pkg::RSS_FETCH_MODE || state_ff == rss_pkg::RSS_FETCH_HI
	             || state_ff == rss_pkg::RSS_FETCH_LO;
	wire [15:0] nxt_rom_addr = (nxt_state == rss_pkg::RSS_FETCH_MODE) ? rss_pkg::MODE_ADDR
	                         : (nxt_state == rss_pkg::RSS_FETCH_HI)   ? rss_pkg::VEC_HI_ADDR
	                         : rss_pkg::VEC_LO_ADDR;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_ff <= rss_pkg::RSS_POR;
		end else if (fetch_st && pin_low) begin
			state_ff <= rss_pkg::RSS_EXTWAIT;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// The ROM is addressed from the next state, so its registered data stand in the fetch state
	// that wants them; a registered address here would put every byte one state late.
	rss_rom #(
		.VECTOR (VECTOR)
	) u_rom (
		.sys_clk (sys_clk),
		.addr    (nxt_rom_addr),
		.rdata   (rom_rdata)
	);

	// ============================================================
	// Timebase timer and internal reset length
	always_ff @(posedge sys_clk) begin
		if (!rst_b || state_ff != rss_pkg::RSS_STAB)
			tbt_ff <= '0;
		else
			tbt_ff <= tbt_ff + 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || state_ff != rss_pkg::RSS_INTRST)
			irst_cnt_ff <= 8'h00;
		else
			irst_cnt_ff <= irst_cnt_ff + 8'h01;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			subclk_at_rst_ff <= 1'b0;
		else if (in_run && int_cause)
			subclk_at_rst_ff <= subclk;
	end

	// ============================================================
	// Control, watchdog, cause
	always_ff @(posedge sys_clk) begin
		if (!rst_b || !in_run)
			ctrl_ff <= rss_pkg::CTRL_RST_VAL;
		else if (wr_ctrl)
			ctrl_ff <= reg_wdata | rss_pkg::CTRL_RST_VAL;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || !in_run || wr_wdt || !wd_en)
			wdt_ff <= '0;
		else
			wdt_ff <= wdt_ff + 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			cause_ff <= 2'h3;
		else if (in_run && pin_low)
			cause_ff <= 2'h0;
		else if (in_run && sw_rst)
			cause_ff <= 2'h1;
		else if (in_run && wd_over)
			cause_ff <= 2'h2;
	end

	// ============================================================
	// Vector capture and CPU handoff
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			vec_ff   <= 16'h0000;
			mode_err <= 1'b0;
		end else begin
			if (state_ff == rss_pkg::RSS_FETCH_MODE)
				mode_err <= (rom_rdata != rss_pkg::MODE_SINGLE)
				         || op_select_pin_hi || op_select_pin_lo;
			if (state_ff == rss_pkg::RSS_FETCH_HI)
				vec_ff[15:8] <= rom_rdata;
		end
	end

	wire entering_run = state_ff == rss_pkg::RSS_FETCH_LO && !pin_low;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cpu_rst_b    <= 1'b0;
			cpu_start    <= 1'b0;
			cpu_start_pc <= 16'h0000;
			ram_clear    <= 1'b0;
		end else begin
			cpu_rst_b <= (nxt_state == rss_pkg::RSS_RUN) && !(fetch_st && pin_low) && !pin_low;
			cpu_start <= entering_run;
			if (entering_run)
				cpu_start_pc <= {vec_ff[15:8], rom_rdata};
			ram_clear <= state_ff == rss_pkg::RSS_POR && POR_OPT;
		end
	end

	// ============================================================
	// Reset pin driver
	wire drive_low = ROUT_OPT && (state_ff == rss_pkg::RSS_STAB
	              || state_ff == rss_pkg::RSS_INTRST);
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ext_rst_pin_oe  <= 1'b0;
			ext_rst_pin_out <= 1'b0;
		end else begin
			ext_rst_pin_oe  <= drive_low;
			ext_rst_pin_out <= 1'b0;
		end
	end

	// ============================================================
	// Register read port
	wire [7:0] stat_word = {3'h0, mode_err, cause_ff, in_run, pin_s2_ff};
	wire [7:0] rd_mux    = (reg_addr == rss_pkg::CTRL_OFS) ? ctrl_ff
	                     : (reg_addr == rss_pkg::STAT_OFS) ? stat_word
	                     : (reg_addr == rss_pkg::VEC_OFS)  ? cpu_start_pc[15:8]
	                     : 8'h00;
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
	end

	// ============================================================
	// Checks
	// Own count of internal reset cycles, so the length check does not lean on irst_cnt_ff.
	logic [7:0] chk_irst_ff;
	always_ff @(posedge sys_clk) begin
		if (!rst_b || state_ff != rss_pkg::RSS_INTRST)
			chk_irst_ff <= 8'h00;
		else
			chk_irst_ff <= chk_irst_ff + 8'h01;
	end
	a_intrst_length: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$fell(state_ff == rss_pkg::RSS_INTRST)
		|-> $past(chk_irst_ff) == rss_pkg::INT_RST_LEN - 8'h01)
		else $error("internal reset length wrong");
	a_wdt_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(in_run && wd_over && !pin_low) |=> state_ff == rss_pkg::RSS_INTRST)
		else $error("watchdog overflow ignored");
	a_pin_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		pin_low |=> !cpu_rst_b || $past(!pin_low))
		else $error("cpu released while pin low");
	a_main_no_stab: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(in_run && pin_low && !osc_off) |=> state_ff == rss_pkg::RSS_EXTWAIT)
		else $error("stabilisation inserted in main clock");
	a_no_por_stab: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!POR_OPT && state_ff != rss_pkg::RSS_INTRST |=> state_ff != rss_pkg::RSS_STAB)
		else $error("stabilisation used without power-on option");
	sequence s_fetch;
		state_ff == rss_pkg::RSS_FETCH_MODE ##1 state_ff == rss_pkg::RSS_FETCH_HI
		##1 state_ff == rss_pkg::RSS_FETCH_LO;
	endsequence
	a_fetch_order: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(s_fetch ##0 !pin_low) |=> in_run ##0 cpu_start ##0 cpu_start_pc == VECTOR)
		else $error("fetch order or vector wrong");
	a_pin_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(ROUT_OPT && state_ff == rss_pkg::RSS_INTRST) |=> ext_rst_pin_oe && !ext_rst_pin_out)
		else $error("reset pin not driven low");
	a_run_mainclk: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(in_run) |-> !subclk && !stopped)
		else $error("run not in main clock mode");
endmodule : rss_seq

//--- rss_board.sv
// Board reset circuit with pull-up and a minimal CPU start counter.
`timescale 1ns/1ps
module rss_board #(
	parameter int PWR_HOLD = 40
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        ext_rst_pin_out,
	input  wire logic        ext_rst_pin_oe,
	input  wire logic        button_low,
	output logic             pin_level,
	input  wire logic        cpu_start,
	output logic      [7:0]  start_cnt_ff
);
	// ============================================================
	// Power-up hold and open-drain wire
	logic [7:0] pwr_cnt_ff;
	logic       pwr_low;

	// The board keeps the line low after power-up until the oscillator has settled.
	assign pwr_low = (pwr_cnt_ff < 8'(PWR_HOLD));

	// Any party may pull low; otherwise the pull-up restores the line high.
	assign pin_level = ~((ext_rst_pin_oe & ~ext_rst_pin_out) | button_low | pwr_low);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pwr_cnt_ff <= 8'h00;
		end else if (pwr_low) begin
			pwr_cnt_ff <= pwr_cnt_ff + 8'h01;
		end
	end

	// ============================================================
	// CPU side: counts the starts of execution
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			start_cnt_ff <= 8'h00;
		end else if (cpu_start) begin
			start_cnt_ff <= start_cnt_ff + 8'h01;
		end
	end
endmodule : rss_board

//--- rss_seq_tb.sv
// Self-checking testbench for the reset source sequencer.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin errors++; \
	$display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module rss_seq_tb;
	localparam logic [15:0] VEC  = 16'hA55A;
	localparam int          HOLD = 40;
	localparam logic [7:0]  STB  = 8'h10;

	// ============================================================
	// Signals
	logic        sys_clk = 1'b0;
	logic        rst_b, pin_level, pin_out, pin_oe, hi_pin, lo_pin, button;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, start_cnt;
	logic        reg_wr, reg_rd, cpu_rst_b, cpu_start, ram_clear, mode_err;
	logic        rd_d = 1'b0;
	logic [15:0] exp_v;
	logic [15:0] cpu_start_pc;
	int          errors = 0;
	int          num_checks = 0;
	int          seed = 98;
	int          elapsed, oe_len;
	int          ram_cnt = 0;
	logic [7:0]  exp_rd[$];
	logic [7:0]  exp_oe[$];
	logic [15:0] exp_pc[$];

	always #4 sys_clk = ~sys_clk;

	rss_seq #(.POR_OPT(1'b1), .ROUT_OPT(1'b1), .STAB_BITS(4), .WDT_BITS(6),
		.VECTOR(VEC)) i_rss_seq (
		.sys_clk(sys_clk), .rst_b(rst_b), .ext_rst_pin_b_in(pin_level),
		.ext_rst_pin_out(pin_out), .ext_rst_pin_oe(pin_oe),
		.op_select_pin_hi(hi_pin), .op_select_pin_lo(lo_pin),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cpu_rst_b(cpu_rst_b), .cpu_start(cpu_start),
		.cpu_start_pc(cpu_start_pc), .ram_clear(ram_clear), .mode_err(mode_err));

	rss_board #(.PWR_HOLD(HOLD)) i_rss_board (
		.sys_clk(sys_clk), .rst_b(rst_b), .ext_rst_pin_out(pin_out),
		.ext_rst_pin_oe(pin_oe), .button_low(button), .pin_level(pin_level),
		.cpu_start(cpu_start), .start_cnt_ff(start_cnt));

	// ============================================================
	// Output monitor: pops the oldest note whenever a result appears
	always @(posedge sys_clk) begin
		if (rd_d) begin
			exp_v = exp_rd.pop_front();
			`CHK("reg_rdata", exp_v, reg_rdata)
		end
		rd_d <= reg_rd;
		if (cpu_start === 1'b1) begin
			exp_v = exp_pc.pop_front();
			`CHK("cpu_start_pc", exp_v, cpu_start_pc)
		end
		if (ram_clear === 1'b1) begin
			ram_cnt++;
		end
		if (!rst_b) begin
			oe_len = 0;
		end else if (pin_oe === 1'b1) begin
			oe_len++;
		end else if (oe_len != 0) begin
			// An empty queue means the pin was driven where it must stay released.
			exp_v = (exp_oe.size() > 0) ? exp_oe.pop_front() : 8'h00;
			`CHK("pin_low_len", exp_v, 16'(oe_len))
			oe_len = 0;
		end
	end

	// ============================================================
	// Register bus tasks
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] ex);
		exp_rd.push_back(ex);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
	endtask : rd

	// Bounded wait for the start pulse; elapsed holds the cycles taken.
	task automatic wait_start();
		elapsed = 0;
		while (cpu_start !== 1'b1 && elapsed < 400) begin
			@(posedge sys_clk);
			#1;
			elapsed++;
		end
		`CHK("start_seen", 1'b1, cpu_start)
		@(posedge sys_clk);
	endtask : wait_start

	task automatic test_done();
		if (errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		test_done();
	end

	// ============================================================
	// Scenarios
	initial begin
		rst_b = 1'b0; hi_pin = 1'b0; lo_pin = 1'b0; button = 1'b0;
		reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		// Power-on: delay with pin driven, then the board's late release.
		exp_oe.push_back(STB);
		exp_pc.push_back(VEC);
		wait_start();
		`CHK("por_after_release", 1'b1, elapsed > HOLD)
		rd(rss_pkg::STAT_OFS, 8'h0F);
		rd(rss_pkg::CTRL_OFS, rss_pkg::CTRL_RST_VAL);
		rd(rss_pkg::VEC_OFS, VEC[15:8]);
		rd(4'hF, 8'h00);
		// Software reset in main clock mode: internal reset only.
		exp_oe.push_back(8'(rss_pkg::INT_RST_CLKS));
		exp_pc.push_back(VEC);
		wr(rss_pkg::CTRL_OFS, 8'h00);
		wait_start();
		rd(rss_pkg::STAT_OFS, 8'h07);
		// Software reset from subclock with a mode pin wrongly high.
		hi_pin <= 1'b1;
		exp_oe.push_back(8'(rss_pkg::INT_RST_CLKS) + STB);
		exp_pc.push_back(VEC);
		// Enter subclock mode first: the mode in force before the reset decides the delay.
		wr(rss_pkg::CTRL_OFS, 8'h05);
		wr(rss_pkg::CTRL_OFS, 8'h04);
		wait_start();
		`CHK("mode_err", 1'b1, mode_err)
		rd(rss_pkg::STAT_OFS, 8'h17);
		rd(rss_pkg::CTRL_OFS, rss_pkg::CTRL_RST_VAL);
		hi_pin <= 1'b0;
		// Watchdog: serviced with random data, then left to expire.
		wr(rss_pkg::CTRL_OFS, 8'h03);
		repeat (4) begin
			repeat (20) @(posedge sys_clk);
			wr(rss_pkg::WDT_OFS, 8'($random(seed)));
		end
		`CHK("wdt_serviced", 1'b1, cpu_rst_b)
		exp_oe.push_back(8'(rss_pkg::INT_RST_CLKS));
		exp_pc.push_back(VEC);
		wait_start();
		rd(rss_pkg::STAT_OFS, 8'h0B);
		// Pin reset in main clock mode: no delay, pin not driven.
		exp_pc.push_back(VEC);
		@(posedge sys_clk);
		button <= 1'b1;
		repeat (5 + ($random(seed) & 15)) @(posedge sys_clk);
		`CHK("pin_holds_reset", 1'b0, cpu_rst_b)
		button <= 1'b0;
		wait_start();
		`CHK("quick_release", 1'b1, elapsed < 10)
		rd(rss_pkg::STAT_OFS, 8'h03);
		// Pin reset in stop mode waits for the stabilisation delay.
		wr(rss_pkg::CTRL_OFS, 8'h09);
		exp_oe.push_back(STB);
		exp_pc.push_back(VEC);
		@(posedge sys_clk);
		button <= 1'b1;
		repeat (3) @(posedge sys_clk);
		button <= 1'b0;
		wait_start();
		rd(rss_pkg::STAT_OFS, 8'h03);
		repeat (3) @(posedge sys_clk);
		`CHK("ram_clear_count", 1, ram_cnt)
		`CHK("starts", 8'h06, start_cnt)
		`CHK("notes_left", 0, exp_rd.size() + exp_pc.size() + exp_oe.size())
		test_done();
	end
endmodule : rss_seq_tb
